// ---- src/dct_pkg.sv ----
// Constants and types for one down-counting timer channel.
// Assumes a single clock domain and a plain register port with 16-bit data.
package dct_pkg;

  // Register addresses on the register port
  localparam logic [15:0] ADDR_CLK_SEL  = 16'h4220;
  localparam logic [15:0] ADDR_RELOAD   = 16'h4222;
  localparam logic [15:0] ADDR_COUNTER  = 16'h4224;
  localparam logic [15:0] ADDR_CONTROL  = 16'h4226;
  localparam logic [15:0] ADDR_IRQ_CTRL = 16'h4228;

  // Control register fields
  localparam int CTL_RUN_BIT      = 0;
  localparam int CTL_PRESET_BIT   = 1;
  localparam int CTL_MODE_BIT     = 4;
  localparam int CTL_SRC_LSB      = 8;
  localparam int CTL_POL_BIT      = 10;
  // Clock select field
  localparam int CLK_SEL_LSB      = 0;
  // Interrupt register fields
  localparam int IRQ_FLAG_BIT     = 0;
  localparam int IRQ_EN_BIT       = 1;
  localparam int IRQ_LVL_LSB      = 4;

  // Reset values
  localparam logic [15:0] RELOAD_RST  = 16'h0000;
  localparam logic [3:0]  CLK_SEL_RST = 4'h0;
  localparam logic        POL_RST     = 1'b1;
  localparam logic [2:0]  IRQ_LVL_RST = 3'h0;

  // Divider select code that has no prescaler tap
  localparam logic [3:0]  CLK_SEL_RESERVED = 4'hf;
  localparam int          PSC_TAPS         = 15;

  // Vector numbering of the timer interrupts
  localparam logic [7:0]  VECTOR_BASE      = 8'h0d;
  localparam logic [15:0] VECTOR_ADDR_BASE = 16'h8034;
  localparam logic [15:0] VECTOR_ADDR_STEP = 16'h0004;

  // Channel that feeds each serial interface
  localparam int SPI_CHANNEL = 1;
  localparam int I2C_CHANNEL = 2;

  typedef enum logic [1:0] {
    DCT_SRC_INTERNAL = 2'b00,
    DCT_SRC_EXTERNAL = 2'b01,
    DCT_SRC_PULSE    = 2'b10,
    DCT_SRC_RESERVED = 2'b11
  } dct_src_t;

  typedef struct packed {
    logic     polarity;
    dct_src_t source;
    logic     one_shot;
    logic     run;
  } dct_ctl_t;

endpackage

// ---- src/dct_timer.sv ----
// One channel of a 16-bit reloadable down-counting timer with register port.
// Assumes prescaler tick enables on clk_in, an asynchronous external pin, and
// an interrupt controller that arbitrates channels by level outside.
`timescale 1ns/1ns
module dct_timer #(
  parameter int CHANNEL = 0
) (
  input  wire logic                           clk_in,
  input  wire logic                           rst_in,
  input  wire logic [15:0]                    addr_in,
  input  wire logic [15:0]                    wr_data_in,
  input  wire logic                           wr_in,
  input  wire logic                           rd_in,
  output logic      [15:0]                    rd_data_out,
  input  wire logic [dct_pkg::PSC_TAPS-1:0]   psc_tick_in,
  input  wire logic                           ext_count_input_in,
  output logic                                underflow_out,
  output logic                                spi_clk_src_out,
  output logic                                i2c_clk_src_out,
  output logic                                irq_req_out,
  output logic      [2:0]                     irq_level_out,
  output logic      [7:0]                     irq_vector_out,
  output logic      [15:0]                    irq_vector_addr_out
);

  logic [15:0]        reload_field;
  logic [15:0]        counter;
  logic [3:0]         clock_divider_sel;
  dct_pkg::dct_ctl_t  ctl;
  logic               timer0_irq_flag;
  logic               timer0_irq_enable;
  logic [2:0]         timer0_irq_level;
  logic               ext_meta;
  logic               ext_sync;
  logic               ext_prev;
  logic               psc_tick;
  logic               in_active;
  logic               edge_hit;
  logic               count_tick;
  logic               uf_event;
  logic               wr_ctl;
  logic               wr_irq;
  logic               counter_preset_trigger;
  logic [15:0]        next_rd_data;

  assign wr_ctl = wr_in && (addr_in == dct_pkg::ADDR_CONTROL);
  assign wr_irq = wr_in && (addr_in == dct_pkg::ADDR_IRQ_CTRL);
  // Strobe exists only in the write cycle, nothing is stored
  assign counter_preset_trigger = wr_ctl && wr_data_in[dct_pkg::CTL_PRESET_BIT];

  // Two flops before any edge or level logic looks at the pin
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      ext_meta <= ext_count_input_in;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Code 15 selects no tap, so the prescaler tick stays low
  always_comb
  begin
    psc_tick = 1'b0;
    if (clock_divider_sel != dct_pkg::CLK_SEL_RESERVED)
      psc_tick = psc_tick_in[clock_divider_sel];
  end

  assign in_active = ctl.polarity ? ext_sync : ~ext_sync;
  assign edge_hit  = ctl.polarity ? (ext_sync & ~ext_prev) : (~ext_sync & ext_prev);

  always_comb
  begin
    count_tick = 1'b0;
    unique case (ctl.source)
      dct_pkg::DCT_SRC_INTERNAL: count_tick = psc_tick;
      dct_pkg::DCT_SRC_EXTERNAL: count_tick = edge_hit;
      dct_pkg::DCT_SRC_PULSE:    count_tick = psc_tick & in_active;
      dct_pkg::DCT_SRC_RESERVED: count_tick = 1'b0;
    endcase
    count_tick = count_tick & ctl.run;
  end

  // Zero then one more tick: reload+1 ticks per period
  assign uf_event = count_tick && (counter == 16'h0000);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      reload_field <= dct_pkg::RELOAD_RST;
    else if (wr_in && addr_in == dct_pkg::ADDR_RELOAD)
      reload_field <= wr_data_in;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      clock_divider_sel <= dct_pkg::CLK_SEL_RST;
    else if (wr_in && addr_in == dct_pkg::ADDR_CLK_SEL)
      clock_divider_sel <= wr_data_in[dct_pkg::CLK_SEL_LSB +: 4];
  end

  // Counter: preset wins over a tick in the same cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      counter <= dct_pkg::RELOAD_RST;
    else if (counter_preset_trigger)
      counter <= reload_field;
    else if (uf_event)
      counter <= reload_field;
    else if (count_tick)
      counter <= counter - 16'h0001;
  end

  // Software write of the control word beats an auto-stop in the same cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctl.polarity <= dct_pkg::POL_RST;
      ctl.source   <= dct_pkg::DCT_SRC_INTERNAL;
      ctl.one_shot <= 1'b0;
      ctl.run      <= 1'b0;
    end
    else if (wr_ctl)
    begin
      ctl.polarity <= wr_data_in[dct_pkg::CTL_POL_BIT];
      ctl.source   <= dct_pkg::dct_src_t'(wr_data_in[dct_pkg::CTL_SRC_LSB +: 2]);
      ctl.one_shot <= wr_data_in[dct_pkg::CTL_MODE_BIT];
      ctl.run      <= wr_data_in[dct_pkg::CTL_RUN_BIT];
    end
    else if (uf_event && ctl.one_shot)
    begin
      ctl.run <= 1'b0;
    end
  end

  // Flag: set by underflow wins over a write-one clear
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      timer0_irq_flag <= 1'b0;
    else if (uf_event)
      timer0_irq_flag <= 1'b1;
    else if (wr_irq && wr_data_in[dct_pkg::IRQ_FLAG_BIT])
      timer0_irq_flag <= 1'b0;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      timer0_irq_enable <= 1'b0;
      timer0_irq_level  <= dct_pkg::IRQ_LVL_RST;
    end
    else if (wr_irq)
    begin
      timer0_irq_enable <= wr_data_in[dct_pkg::IRQ_EN_BIT];
      timer0_irq_level  <= wr_data_in[dct_pkg::IRQ_LVL_LSB +: 3];
    end
  end

  // Outputs, all registered
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      underflow_out   <= 1'b0;
      spi_clk_src_out <= 1'b0;
      i2c_clk_src_out <= 1'b0;
      irq_req_out     <= 1'b0;
      irq_level_out   <= dct_pkg::IRQ_LVL_RST;
    end
    else
    begin
      underflow_out   <= uf_event;
      spi_clk_src_out <= (CHANNEL == dct_pkg::SPI_CHANNEL) && uf_event;
      i2c_clk_src_out <= (CHANNEL == dct_pkg::I2C_CHANNEL) && uf_event;
      irq_req_out     <= (timer0_irq_flag || uf_event) && timer0_irq_enable;
      irq_level_out   <= timer0_irq_level;
    end
  end

  // Per-channel vector; arbitration between channels sits in the controller
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_vector_out      <= 8'h00;
      irq_vector_addr_out <= 16'h0000;
    end
    else
    begin
      irq_vector_out      <= dct_pkg::VECTOR_BASE + 8'(CHANNEL);
      irq_vector_addr_out <= dct_pkg::VECTOR_ADDR_BASE
                             + 16'(CHANNEL) * dct_pkg::VECTOR_ADDR_STEP;
    end
  end

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb
  begin
    next_rd_data = 16'h0000;
    unique case (addr_in)
      dct_pkg::ADDR_CLK_SEL:  next_rd_data[dct_pkg::CLK_SEL_LSB +: 4] = clock_divider_sel;
      dct_pkg::ADDR_RELOAD:   next_rd_data = reload_field;
      dct_pkg::ADDR_COUNTER:  next_rd_data = counter;
      dct_pkg::ADDR_CONTROL:
      begin
        next_rd_data[dct_pkg::CTL_RUN_BIT]       = ctl.run;
        next_rd_data[dct_pkg::CTL_MODE_BIT]      = ctl.one_shot;
        next_rd_data[dct_pkg::CTL_SRC_LSB +: 2]  = ctl.source;
        next_rd_data[dct_pkg::CTL_POL_BIT]       = ctl.polarity;
      end
      dct_pkg::ADDR_IRQ_CTRL:
      begin
        next_rd_data[dct_pkg::IRQ_FLAG_BIT]      = timer0_irq_flag;
        next_rd_data[dct_pkg::IRQ_EN_BIT]        = timer0_irq_enable;
        next_rd_data[dct_pkg::IRQ_LVL_LSB +: 3]  = timer0_irq_level;
      end
      default:                next_rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rd_data_out <= 16'h0000;
    else if (rd_in)
      rd_data_out <= next_rd_data;
    else
      rd_data_out <= 16'h0000;
  end

  // Checks
  property p_pulse_hold;
    @(posedge clk_in) disable iff (rst_in)
    (ctl.source == dct_pkg::DCT_SRC_PULSE && !in_active && !counter_preset_trigger)
      |=> (counter == $past(counter));
  endproperty
  a_pulse_hold: assert property (p_pulse_hold)
    else $error("counter moved while pulse input inactive");

  property p_pulse_polarity;
    @(posedge clk_in) disable iff (rst_in)
    (ctl.source == dct_pkg::DCT_SRC_PULSE && ctl.run && psc_tick && counter != 16'h0000
     && (ctl.polarity == ext_sync) && !counter_preset_trigger)
      |=> (counter == $past(counter) - 16'h0001);
  endproperty
  a_pulse_polarity: assert property (p_pulse_polarity)
    else $error("pulse mode missed a tick at active level");

  property p_repeat_keeps_running;
    @(posedge clk_in) disable iff (rst_in)
    (uf_event && !ctl.one_shot && !wr_ctl) |=> ctl.run;
  endproperty
  a_repeat_keeps_running: assert property (p_repeat_keeps_running)
    else $error("repeat mode stopped on underflow");

  property p_one_shot_stops;
    @(posedge clk_in) disable iff (rst_in)
    (uf_event && ctl.one_shot && !wr_ctl) |=> (!ctl.run && counter == $past(reload_field));
  endproperty
  a_one_shot_stops: assert property (p_one_shot_stops)
    else $error("one-shot did not reload and stop");

  property p_underflow_reload;
    @(posedge clk_in) disable iff (rst_in)
    (uf_event && !counter_preset_trigger)
      |=> (counter == $past(reload_field)) && underflow_out && timer0_irq_flag;
  endproperty
  a_underflow_reload: assert property (p_underflow_reload)
    else $error("underflow without reload, pulse or flag");

  property p_preset_loads;
    @(posedge clk_in) disable iff (rst_in)
    counter_preset_trigger |=> (counter == $past(reload_field));
  endproperty
  a_preset_loads: assert property (p_preset_loads)
    else $error("preset did not load reload value");

  property p_stopped_holds;
    @(posedge clk_in) disable iff (rst_in)
    (!ctl.run && !counter_preset_trigger) |=> $stable(counter);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("counter changed while stopped");

  property p_irq_needs_enable;
    @(posedge clk_in) disable iff (rst_in)
    (!timer0_irq_enable)[*2] |-> !irq_req_out;
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable)
    else $error("interrupt request with enable clear");

  property p_irq_follows_underflow;
    @(posedge clk_in) disable iff (rst_in)
    (uf_event && timer0_irq_enable && !wr_irq) |=> irq_req_out && underflow_out;
  endproperty
  a_irq_follows_underflow: assert property (p_irq_follows_underflow)
    else $error("underflow did not raise request");

  property p_preset_reads_zero;
    @(posedge clk_in) disable iff (rst_in)
    (rd_in && addr_in == dct_pkg::ADDR_CONTROL) |=> !rd_data_out[dct_pkg::CTL_PRESET_BIT];
  endproperty
  a_preset_reads_zero: assert property (p_preset_reads_zero)
    else $error("preset bit read back as one");

  property p_ext_edge_counts;
    @(posedge clk_in) disable iff (rst_in)
    (ctl.source == dct_pkg::DCT_SRC_EXTERNAL && ctl.run && ctl.polarity
     && ext_sync && !ext_prev && counter != 16'h0000 && !counter_preset_trigger)
      |=> (counter == $past(counter) - 16'h0001);
  endproperty
  a_ext_edge_counts: assert property (p_ext_edge_counts)
    else $error("rising edge not counted in external mode");

  property p_uf_single;
    @(posedge clk_in) disable iff (rst_in)
    // Reload of zero legally underflows on every tick
    (uf_event && reload_field != 16'h0000) |=> !uf_event;
  endproperty
  a_uf_single: assert property (p_uf_single)
    else $error("underflow on two adjacent cycles");

endmodule

// ---- testbench/dct_pin_model.sv ----
// Far-side model: prescaler tap enables and the external count pin.
// Assumes the bench sets the wanted pin level through pin_level_in.
`timescale 1ns/1ns
module dct_pin_model (
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  input  wire logic                         pin_level_in,
  output logic [dct_pkg::PSC_TAPS-1:0]      psc_tick_out,
  output logic                              pin_out
);
  logic [13:0] div_cnt;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      div_cnt <= 14'h0000;
    else
      div_cnt <= div_cnt + 14'h0001;
  end

  // Tap n fires once every 2^n clocks, tap 0 on every clock
  always_comb
  begin
    for (int n = 0; n < dct_pkg::PSC_TAPS; n++)
      psc_tick_out[n] = ((div_cnt & ((14'h0001 << n) - 14'h0001)) == 14'h0000);
  end

  // Pin is always driven, so it never floats
  assign pin_out = pin_level_in;
endmodule

// ---- testbench/down_counter_timer_channel_tb.sv ----
// Self-checking bench for one timer channel, instance set up as channel 1.
// Assumes the far-side model for prescaler taps and the count pin.
`timescale 1ns/1ns
module down_counter_timer_channel_tb;
  logic                         clk_in;
  logic                         rst_in;
  logic [15:0]                  addr_in;
  logic [15:0]                  wr_data_in;
  logic                         wr_in;
  logic                         rd_in;
  logic [15:0]                  rd_data_out;
  logic [dct_pkg::PSC_TAPS-1:0] psc_tick;
  logic                         pin_level;
  logic                         pin;
  logic                         underflow_out;
  logic                         spi_clk_src_out;
  logic                         i2c_clk_src_out;
  logic                         irq_req_out;
  logic [2:0]                   irq_level_out;
  logic [7:0]                   irq_vector_out;
  logic [15:0]                  irq_vector_addr_out;
  logic [15:0]                  rd_q[$];
  logic                         rd_seen = 1'b0;
  logic [15:0]                  reload;
  logic [15:0]                  width;
  logic [15:0]                  bit_clks;
  int                           num_errors;
  int                           checks;
  int                           gap;

  dct_timer #(.CHANNEL(1)) u_dut (
    .clk_in              (clk_in),
    .rst_in              (rst_in),
    .addr_in             (addr_in),
    .wr_data_in          (wr_data_in),
    .wr_in               (wr_in),
    .rd_in               (rd_in),
    .rd_data_out         (rd_data_out),
    .psc_tick_in         (psc_tick),
    .ext_count_input_in  (pin),
    .underflow_out       (underflow_out),
    .spi_clk_src_out     (spi_clk_src_out),
    .i2c_clk_src_out     (i2c_clk_src_out),
    .irq_req_out         (irq_req_out),
    .irq_level_out       (irq_level_out),
    .irq_vector_out      (irq_vector_out),
    .irq_vector_addr_out (irq_vector_addr_out)
  );

  dct_pin_model u_far (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .pin_level_in (pin_level),
    .psc_tick_out (psc_tick),
    .pin_out      (pin)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  function automatic logic [15:0] ctl(input logic run, input logic pre, input logic os,
                                      input logic [1:0] src, input logic pol);
    return {5'h00, pol, src, 3'h0, os, 2'h0, pre, run};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Gap cycle after each strobe keeps every signal to one assignment per step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    rd_q.push_back(exp);
    @(posedge clk_in);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_in)
  begin
    if (rd_seen)
      check(rd_data_out, rd_q.pop_front());
    rd_seen <= rd_in;
  end

  task automatic wait_uf(output int n);
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (underflow_out !== 1'b1 && n < 5000);
    if (underflow_out !== 1'b1)
    begin
      num_errors++;
      print_verdict();
    end
    else
      check({14'h0, spi_clk_src_out, i2c_clk_src_out}, 16'h0002);
  endtask

  initial
  begin
    rst_in = 1'b1;
    addr_in = 16'h0000;
    wr_data_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    pin_level = 1'b0;
    num_errors = 0;
    checks = 0;
    void'($urandom(32'h1b8efcae));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({8'h00, irq_vector_out}, 16'h000e);
    check(irq_vector_addr_out, 16'h8038);
    rd(dct_pkg::ADDR_RELOAD, 16'h0000);
    rd(dct_pkg::ADDR_CONTROL, ctl(0, 0, 0, 2'h0, 1));
    rd(dct_pkg::ADDR_CLK_SEL, 16'h0000);
    rd(dct_pkg::ADDR_IRQ_CTRL, 16'h0000);
    rd(16'h4230, 16'h0000);
    $display("test reset done");

    // Setup order: reload, then source, mode and preset in one write, then run
    // Bit period of 8 to 18 clocks on tap 0, reload from the rate formula
    bit_clks = 16'h0002 * (16'($urandom % 6) + 16'h0004);
    reload = bit_clks / 16'h0002 - 16'h0001;
    wr(dct_pkg::ADDR_RELOAD, reload);
    wr(dct_pkg::ADDR_CONTROL, ctl(0, 1, 0, 2'h0, 1));
    wr(dct_pkg::ADDR_COUNTER, 16'hbeef);
    rd(dct_pkg::ADDR_COUNTER, reload);
    rd(dct_pkg::ADDR_CONTROL, ctl(0, 0, 0, 2'h0, 1));
    wr(dct_pkg::ADDR_CONTROL, ctl(1, 0, 0, 2'h0, 1));
    wait_uf(gap);
    check(16'(gap), reload + 16'h0001);
    check(16'(gap) * 16'h0002, bit_clks);
    wait_uf(gap);
    check(16'(gap), reload + 16'h0001);
    rd(dct_pkg::ADDR_IRQ_CTRL, 16'h0001);
    check({15'h0000, irq_req_out}, 16'h0000);
    wr(dct_pkg::ADDR_IRQ_CTRL, 16'h0073);
    wait_uf(gap);
    @(posedge clk_in);
    check({15'h0000, irq_req_out}, 16'h0001);
    check({13'h0000, irq_level_out}, 16'h0007);
    check({15'h0000, underflow_out}, 16'h0000);
    wait_uf(gap);
    wr(dct_pkg::ADDR_CONTROL, ctl(0, 0, 0, 2'h0, 1));
    wr(dct_pkg::ADDR_IRQ_CTRL, 16'h0001);
    rd(dct_pkg::ADDR_COUNTER, reload - 16'h0002);
    rd(dct_pkg::ADDR_COUNTER, reload - 16'h0002);
    wr(dct_pkg::ADDR_CONTROL, ctl(1, 0, 0, 2'h0, 1));
    wait_uf(gap);
    check(16'(gap), reload - 16'h0001);
    $display("test repeat done");

    wr(dct_pkg::ADDR_CONTROL, ctl(0, 1, 1, 2'h0, 1));
    wr(dct_pkg::ADDR_CONTROL, ctl(1, 0, 1, 2'h0, 1));
    wait_uf(gap);
    check(16'(gap), reload + 16'h0001);
    rd(dct_pkg::ADDR_CONTROL, ctl(0, 0, 1, 2'h0, 1));
    rd(dct_pkg::ADDR_COUNTER, reload);
    $display("test one-shot done");

    wr(dct_pkg::ADDR_CLK_SEL, 16'h0002);
    wr(dct_pkg::ADDR_CONTROL, ctl(0, 1, 0, 2'h0, 1));
    wr(dct_pkg::ADDR_CONTROL, ctl(1, 0, 0, 2'h0, 1));
    wait_uf(gap);
    wait_uf(gap);
    check(16'(gap), (reload + 16'h0001) * 16'h0004);
    wr(dct_pkg::ADDR_CONTROL, ctl(0, 1, 0, 2'h0, 1));
    wr(dct_pkg::ADDR_CLK_SEL, 16'h000f);
    wr(dct_pkg::ADDR_CONTROL, ctl(1, 0, 0, 2'h0, 1));
    repeat (8) @(posedge clk_in);
    rd(dct_pkg::ADDR_COUNTER, reload);
    wr(dct_pkg::ADDR_CONTROL, ctl(0, 0, 0, 2'h0, 1));
    wr(dct_pkg::ADDR_CLK_SEL, 16'h0000);
    wr(dct_pkg::ADDR_CONTROL, ctl(1, 0, 0, 2'h3, 1));
    repeat (8) @(posedge clk_in);
    rd(dct_pkg::ADDR_COUNTER, reload);
    wr(dct_pkg::ADDR_CONTROL, ctl(0, 0, 0, 2'h0, 1));
    $display("test divider done");

    // Three active pulses: pulse mode counts their width, event mode their edges
    for (int s = 2; s >= 1; s--)
    begin
      for (int p = 1; p >= 0; p--)
      begin
        width = 16'($urandom % 5) + 16'h0002;
        pin_level <= ~p[0];
        wr(dct_pkg::ADDR_RELOAD, 16'h0100);
        wr(dct_pkg::ADDR_CONTROL, ctl(0, 1, 0, s[1:0], p[0]));
        wr(dct_pkg::ADDR_CONTROL, ctl(1, 0, 0, s[1:0], p[0]));
        repeat (3)
        begin
          pin_level <= p[0];
          repeat (width) @(posedge clk_in);
          pin_level <= ~p[0];
          repeat (3) @(posedge clk_in);
        end
        repeat (6) @(posedge clk_in);
        rd(dct_pkg::ADDR_COUNTER, 16'h0100 - ((s == 2) ? width * 16'h0003 : 16'h0003));
        repeat (5) @(posedge clk_in);
        rd(dct_pkg::ADDR_COUNTER, 16'h0100 - ((s == 2) ? width * 16'h0003 : 16'h0003));
        wr(dct_pkg::ADDR_CONTROL, ctl(0, 0, 0, s[1:0], p[0]));
      end
    end
    $display("test pin modes done");
    print_verdict();
  end
endmodule
